// *** rtl/wos_sequencer.sv ***
// waveform output sequencer: apb registers, sample buffer, pacing and triggers
module wos_sequencer
  import wos_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        generation_begin_input,
  input  wire logic        generation_hold_input,
  input  wire logic        ext_pace_input,
  output logic      [15:0] first_converter,
  output logic      [15:0] second_converter,
  output logic             output_update_strobe
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [8:0]        ctrl_q;
  logic [15:0]       div_q;
  logic [15:0]       dly_q;
  logic [15:0]       cnt_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic [2:0]        sync1_q;
  logic [2:0]        sync2_q;
  logic [2:0]        sync3_q;
  wos_state_t        state_q;
  logic [15:0]       pace_q;
  logic [15:0]       rem_q;
  logic              err_q;
  logic              done_q;
  logic              rej_q;
  logic              single_q;
  logic [31:0]       mem [WOS_DEPTH];
  logic [WOS_AW-1:0] wr_ptr_q;
  logic [WOS_AW-1:0] rd_ptr_q;
  logic [WOS_AW-1:0] rep_q;
  logic [WOS_AW:0]   level_q;
  logic [15:0]       conv0_q;
  logic [15:0]       conv1_q;
  logic              strobe_q;

  logic              acc;
  logic              wr;
  logic              cmd_wr;
  logic              ctrl_wr;
  logic              data_wr;
  logic [31:0]       cmd;
  logic              hw;
  logic              cont;
  wos_regen_t        regen;
  logic              replay;
  logic              empty;
  logic              full;
  logic              push;
  logic              pause;
  logic              trig_edge;
  logic              ext_rise;
  logic              tick;
  logic              due;
  logic              pop;
  logic              uflow;
  logic              fin_end;
  logic [WOS_AW-1:0] rd_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  assign acc     = psel & penable & pready_q;
  assign wr      = acc & pwrite;
  assign cmd_wr  = wr & (paddr == WOS_CMD_OFS);
  assign ctrl_wr = wr & (paddr == WOS_CTRL_OFS);
  assign data_wr = wr & (paddr == WOS_DATA_OFS);
  assign cmd     = cmd_wr ? pwdata : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= 1'b0;
      if (psel & penable & ~pready_q)
      begin
        prdata_q <= 32'h0;
        case (paddr)
          WOS_CTRL_OFS: prdata_q <= {23'h0, ctrl_q};
          WOS_DIV_OFS:  prdata_q <= {16'h0, div_q};
          WOS_DLY_OFS:  prdata_q <= {16'h0, dly_q};
          WOS_CNT_OFS:  prdata_q <= {16'h0, cnt_q};
          WOS_STAT_OFS: prdata_q <= {rem_q, 1'b0, level_q, 2'h0, rej_q, full, empty,
                                     done_q, err_q, state_q != WOS_IDLE};
          WOS_CMD_OFS,
          WOS_DATA_OFS: prdata_q <= 32'h0;
          default:      pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= WOS_CTRL_RST;
      div_q  <= WOS_DIV_RST;
      dly_q  <= WOS_DLY_RST;
      cnt_q  <= WOS_CNT_RST;
    end
    else if (wr)
    begin
      case (paddr)
        WOS_CTRL_OFS: ctrl_q <= pwdata[8:0];
        WOS_DIV_OFS:  div_q  <= pwdata[15:0];
        WOS_DLY_OFS:  dly_q  <= pwdata[15:0];
        WOS_CNT_OFS:  cnt_q  <= pwdata[15:0];
        default:      ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign hw     = ctrl_q[WOS_C_HW];
  assign cont   = ctrl_q[WOS_C_CONT];
  assign regen  = wos_regen_t'(ctrl_q[WOS_C_REGEN+:2]);
  assign replay = hw & cont & (regen == WOS_REGEN_LOCAL);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and trigger detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {ext_pace_input, generation_hold_input, generation_begin_input};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign trig_edge = ctrl_q[WOS_C_TRIGFALL] ? (sync3_q[0] & ~sync2_q[0])   // RL12
                                            : (~sync3_q[0] & sync2_q[0]);
  assign pause     = ctrl_q[WOS_C_PAUSE] & (sync2_q[1] ^ ctrl_q[WOS_C_PAUSELOW]); // RL12
  assign ext_rise  = ~sync3_q[2] & sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // pacing and sequencing
  assign tick = ~pause & (pace_q <= 16'h0001);                                   // RL14
  always_comb
  begin
    due = 1'b0;
    if (!hw)
      due = single_q;                                                            // RL4
    else if (state_q == WOS_RUN)
      due = ~pause & (ctrl_q[WOS_C_EXTPACE] ? ext_rise : tick);                  // RL5
    else if (state_q == WOS_DELAY)
      due = tick;                                                                // RL15
  end

  assign pop     = due & ~empty & ~err_q;                                        // RL2
  assign uflow   = due & hw & empty & (~cont | (regen == WOS_REGEN_NONE));       // RL11
  assign fin_end = pop & hw & ~cont & (rem_q <= 16'h0001);                       // RL7

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      single_q <= 1'b0;
    else
      single_q <= cmd[WOS_K_SINGLE] & ~hw;                                       // RL4
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= WOS_IDLE;
    else if (ctrl_wr | cmd[WOS_K_STOP] | uflow | err_q | fin_end)
      state_q <= WOS_IDLE;                                                       // RL8 RL16
    else
    begin
      case (state_q)
        WOS_IDLE:
          if (cmd[WOS_K_START] & hw)
            state_q <= WOS_ARMED;
        WOS_ARMED:
          if (!ctrl_q[WOS_C_TRIG] | trig_edge)                                   // RL13
            state_q <= ctrl_q[WOS_C_EXTPACE] ? WOS_RUN : WOS_DELAY;
        WOS_DELAY:
          if (due)
            state_q <= WOS_RUN;                                                  // RL15
        WOS_RUN:
          state_q <= WOS_RUN;                                                    // RL8
        default:
          state_q <= WOS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pace_q <= WOS_DLY_RST;
    else if (state_q == WOS_ARMED)
      pace_q <= dly_q;                                                           // RL15
    else if ((state_q == WOS_DELAY) | (state_q == WOS_RUN))
    begin
      if (tick)
        pace_q <= div_q;                                                         // RL5
      else if (!pause)
        pace_q <= pace_q - 16'h0001;                                             // RL14
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rem_q <= WOS_CNT_RST;
    else if (state_q == WOS_IDLE)
      rem_q <= cnt_q;
    else if (pop)
      rem_q <= rem_q - 16'h0001;                                                 // RL7
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_q  <= 1'b0;
      done_q <= 1'b0;
      rej_q  <= 1'b0;
    end
    else
    begin
      err_q  <= uflow | (err_q & ~cmd[WOS_K_CLRERR] & ~ctrl_wr);                 // RL16
      done_q <= fin_end | (done_q & ~cmd[WOS_K_START] & ~ctrl_wr);
      rej_q  <= (data_wr & ~push) | (rej_q & ~cmd[WOS_K_CLRERR] & ~ctrl_wr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample buffer
  assign empty   = (level_q == '0);
  assign full    = level_q[WOS_AW];
  assign push    = data_wr & ~full & ~(replay & (state_q != WOS_IDLE));          // RL10
  assign rd_addr = replay ? (rd_ptr_q + rep_q) : rd_ptr_q;

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_q] <= pwdata;                                                   // RL3 RL6
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      rep_q    <= '0;
      level_q  <= '0;
    end
    else if (cmd[WOS_K_FLUSH] & (state_q == WOS_IDLE))
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      rep_q    <= '0;
      level_q  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop & replay)                                                          // RL10
        rep_q <= ({1'b0, rep_q} + 1'b1 >= level_q) ? '0 : rep_q + 1'b1;
      else if (!replay)
        rep_q <= '0;
      if (pop & ~replay)
        rd_ptr_q <= rd_ptr_q + 1'b1;                                             // RL11
      level_q <= level_q + {{WOS_AW{1'b0}}, push} - {{WOS_AW{1'b0}}, pop & ~replay}; // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv0_q  <= 16'h0;
      conv1_q  <= 16'h0;
      strobe_q <= 1'b0;
    end
    else
    begin
      strobe_q <= pop;                                                           // RL1
      if (pop)
      begin
        conv0_q <= mem[rd_addr][15:0];                                           // RL1 RL2
        conv1_q <= mem[rd_addr][31:16];
      end
    end
  end

  assign first_converter      = conv0_q;
  assign second_converter     = conv1_q;
  assign output_update_strobe = strobe_q;
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence arm_seq;
    state_q == WOS_ARMED && !ctrl_q[WOS_C_EXTPACE] && (!ctrl_q[WOS_C_TRIG] || trig_edge)
      && !ctrl_wr && !cmd[WOS_K_STOP] && !err_q && dly_q == WOS_DLY_RST;
  endsequence

  sequence quiet_seq;
    (!pause && !ctrl_wr && !cmd[WOS_K_STOP]) ##1 !pause;
  endsequence

  shared_update_a: assert property (pop |=> output_update_strobe &&             // RL1
    first_converter == $past(mem[rd_addr][15:0]) &&
    second_converter == $past(mem[rd_addr][31:16]))
    else $error("converters not loaded together");

  one_pop_a: assert property (pop && !replay && !push |=> level_q == $past(level_q) - 1) // RL2
    else $error("update did not remove one sample");

  buf_fill_a: assert property (push && !pop |=> level_q == $past(level_q) + 1)   // RL3
    else $error("write not held in buffer");

  host_single_a: assert property (cmd_wr && pwdata[WOS_K_SINGLE] && !hw && !empty && !err_q
    ##1 !ctrl_wr |-> ##0 pop ##1 !pop)                                           // RL4
    else $error("host command not exactly one update");

  first_delay_a: assert property (arm_seq ##1 quiet_seq |-> !$past(pop) && (pop || empty)) // RL15
    else $error("first update not two ticks after start");

  finite_stop_a: assert property (fin_end |=> state_q == WOS_IDLE && done_q)    // RL7
    else $error("finite generation did not stop");

  cont_run_a: assert property (state_q == WOS_RUN && cont && !ctrl_wr && !cmd[WOS_K_STOP]
    && !uflow |=> state_q == WOS_RUN)                                            // RL8
    else $error("continuous generation stopped by itself");

  replay_hold_a: assert property (replay && state_q != WOS_IDLE && data_wr |=> rej_q
    && level_q == $past(level_q))                                                // RL10
    else $error("buffer-local replay accepted a write");

  underflow_a: assert property (uflow |=> err_q && state_q == WOS_IDLE)          // RL11
    else $error("underflow not flagged");

  pause_hold_a: assert property (pause && hw |-> !pop)                           // RL14
    else $error("update during pause");

  err_sticky_a: assert property (err_q && !cmd[WOS_K_CLRERR] && !ctrl_wr |=> err_q && !pop) // RL16
    else $error("error flag dropped or updates continued");

endmodule

// *** rtl/wos_pkg.sv ***
// constants and types of the waveform output sequencer
//
// What this block does
// (RL1) Both converters are loaded together on one shared update strobe.
// (RL2) Every update loads one sample from the buffer into the converters and, except in buffer-local regeneration, removes it from the buffer.
// (RL3) Samples wait in a first-in first-out buffer between the host path and the converters.
// (RL4) In host-timed mode each host update command gives exactly one converter update.
// (RL5) In hardware-timed mode updates are paced by an internal divider or an external input.
// (RL6) In hardware-timed mode host blocks fill the buffer and play out one sample per update.
// (RL7) Finite generation plays a preset number of samples and then stops by itself.
// (RL8) Continuous generation runs with no sample limit until the host asks it to stop, or until underflow in non-regeneration.
// (RL9) Standard regeneration keeps playing while the host keeps refilling the buffer.
// (RL10) Buffer-local regeneration replays the loaded buffer and refuses new writes once started.
// (RL11) Non-regeneration never replays a sample and flags underflow when the buffer runs dry.
// (RL12) Generation has a start action and a pause action, each able to come from a trigger input.
// (RL13) Generation starts on the start trigger edge, or on a host command when no trigger is used.
// (RL14) In hardware-timed mode no updates happen while the pause input is in its active state.
// (RL15) With internal pacing the first update follows the start after a delay, two ticks by default.
// (RL16) Underflow stays flagged until cleared or reconfigured, and updates stop meanwhile.
package wos_pkg;

  localparam int          WOS_DEPTH      = 64;
  localparam int          WOS_AW         = 6;

  localparam logic [7:0]  WOS_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  WOS_CMD_OFS    = 8'h04;
  localparam logic [7:0]  WOS_DIV_OFS    = 8'h08;
  localparam logic [7:0]  WOS_DLY_OFS    = 8'h0c;
  localparam logic [7:0]  WOS_CNT_OFS    = 8'h10;
  localparam logic [7:0]  WOS_DATA_OFS   = 8'h14;
  localparam logic [7:0]  WOS_STAT_OFS   = 8'h18;

  // control bit positions
  localparam int          WOS_C_HW       = 0;
  localparam int          WOS_C_CONT     = 1;
  localparam int          WOS_C_REGEN    = 2;
  localparam int          WOS_C_EXTPACE  = 4;
  localparam int          WOS_C_TRIG     = 5;
  localparam int          WOS_C_TRIGFALL = 6;
  localparam int          WOS_C_PAUSE    = 7;
  localparam int          WOS_C_PAUSELOW = 8;

  // command bit positions
  localparam int          WOS_K_START    = 0;
  localparam int          WOS_K_STOP     = 1;
  localparam int          WOS_K_SINGLE   = 2;
  localparam int          WOS_K_CLRERR   = 3;
  localparam int          WOS_K_FLUSH    = 4;

  // status bit positions
  localparam int          WOS_S_RUN      = 0;
  localparam int          WOS_S_ERR      = 1;
  localparam int          WOS_S_DONE     = 2;
  localparam int          WOS_S_EMPTY    = 3;
  localparam int          WOS_S_FULL     = 4;
  localparam int          WOS_S_REJ      = 5;
  localparam int          WOS_S_LEVEL    = 8;
  localparam int          WOS_S_REM      = 16;

  localparam logic [8:0]  WOS_CTRL_RST   = 9'h000;
  localparam logic [15:0] WOS_DIV_RST    = 16'h0064;
  localparam logic [15:0] WOS_DLY_RST    = 16'h0002;
  localparam logic [15:0] WOS_CNT_RST    = 16'h0001;

  typedef enum logic [1:0] {
    WOS_REGEN_STD   = 2'h0,
    WOS_REGEN_LOCAL = 2'h1,
    WOS_REGEN_NONE  = 2'h2
  } wos_regen_t;

  typedef enum logic [1:0] {
    WOS_IDLE  = 2'h0,
    WOS_ARMED = 2'h1,
    WOS_DELAY = 2'h3,
    WOS_RUN   = 2'h2
  } wos_state_t;

endpackage

// *** verification/wos_host_model.sv ***
// host model: apb master that hands samples and commands to the block
module wos_host_model
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic        rerr;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// *** verification/waveform_output_sequencer_tb.sv ***
// testbench of the waveform output sequencer
module waveform_output_sequencer_tb
  import wos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, output_update_strobe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] first_converter, second_converter;
  logic        generation_begin_input = 1'b0;
  logic        generation_hold_input = 1'b0;
  logic        ext_pace_input = 1'b0;
  logic [31:0] last_w = 32'h0;
  logic [31:0] seen_q[$];
  int          err_total = 0;
  int          checks = 0;

  always #5 pclk = ~pclk;

  wos_sequencer wos_sequencer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .generation_begin_input,
    .generation_hold_input, .ext_pace_input, .first_converter, .second_converter,
    .output_update_strobe);
  wos_host_model host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] smp(input int i);
    return {16'ha000 + 16'(i), 16'h5000 + 16'(i)};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_i.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    host_i.xfer(1'b0, a, 32'h0);
  endtask

  task automatic go(input logic [31:0] ctrl, input int n, input int b);
    wr(WOS_CTRL_OFS, ctrl);
    wr(WOS_CMD_OFS, 32'h1 << WOS_K_FLUSH);
    for (int i = 0; i < n; i++)
      wr(WOS_DATA_OFS, smp(b + i));
    seen_q.delete();
    wr(WOS_CMD_OFS, 32'h1 << WOS_K_START);
  endtask

  task automatic cnt(input int n);
    chk(32'(seen_q.size()), 32'(n));
  endtask

  // both words change only on the shared strobe
  always @(posedge pclk)
  begin
    if (output_update_strobe === 1'b1)
      seen_q.push_back({second_converter, first_converter});
    else if (presetn === 1'b1)
      chk({second_converter, first_converter}, last_w);
    last_w = {second_converter, first_converter};
  end

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(WOS_CTRL_OFS);
    chk(host_i.rdata, 32'h0);
    rd(WOS_DIV_OFS);
    chk(host_i.rdata, 32'h64);
    rd(WOS_DLY_OFS);
    chk(host_i.rdata, 32'h2);
    rd(WOS_CNT_OFS);
    chk(host_i.rdata, 32'h1);
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h7f3f, 32'h0008);
    rd(8'h40);
    chk({31'h0, host_i.rerr}, 32'h1);
  endtask

  task automatic t_single();
    go(32'h0, 2, 0);
    for (int i = 0; i < 2; i++)
    begin
      wr(WOS_CMD_OFS, 32'h1 << WOS_K_SINGLE);
      idle(4);
      cnt(i + 1);
      chk(seen_q[i], smp(i));
    end
  endtask

  task automatic t_delay(input int d);
    int n;
    n = 0;
    wr(WOS_DIV_OFS, 32'h4);
    wr(WOS_CNT_OFS, 32'h1);
    wr(WOS_DLY_OFS, 32'(d));
    go(32'h1, 1, 30);
    while (output_update_strobe !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'(2 + d));
    wr(WOS_DLY_OFS, 32'h2);
  endtask

  task automatic t_finite();
    wr(WOS_CNT_OFS, 32'h3);
    go(32'h1, 4, 40);
    idle(60);
    cnt(3);
    for (int i = 0; i < 3; i++)
      chk(seen_q[i], smp(40 + i));
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h7f3f, 32'h0104);
  endtask

  task automatic t_std();
    go(32'h3, 2, 50);
    idle(40);
    cnt(2);
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h3, 32'h1);
    wr(WOS_DATA_OFS, smp(60));
    idle(20);
    cnt(3);
    chk(seen_q[2], smp(60));
  endtask

  task automatic t_local();
    go(32'h7, 2, 70);
    idle(30);
    chk(32'(seen_q.size() >= 5), 32'h1);
    foreach (seen_q[i])
      chk(seen_q[i], smp(70 + i % 2));
    wr(WOS_DATA_OFS, smp(80));
    rd(WOS_STAT_OFS);
    chk((host_i.rdata >> WOS_S_REJ) & 32'h1, 32'h1);
    wr(WOS_CMD_OFS, 32'h1 << WOS_K_STOP);
    seen_q.delete();
    idle(20);
    cnt(0);
  endtask

  task automatic t_under();
    go(32'hb, 2, 90);
    idle(40);
    cnt(2);
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h3, 32'h2);
    wr(WOS_DATA_OFS, smp(95));
    idle(30);
    cnt(2);
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h2, 32'h2);
    wr(WOS_CMD_OFS, 32'h1 << WOS_K_CLRERR);
    rd(WOS_STAT_OFS);
    chk(host_i.rdata & 32'h2, 32'h0);
  endtask

  task automatic t_trig();
    int n;
    wr(WOS_DIV_OFS, 32'h14);
    go(32'ha3, 6, 100);
    idle(30);
    cnt(0);
    generation_begin_input <= 1'b1;
    idle(30);
    chk(32'(seen_q.size() >= 1), 32'h1);
    generation_hold_input <= 1'b1;
    idle(4);
    n = seen_q.size();
    idle(60);
    cnt(n);
    generation_hold_input <= 1'b0;
    idle(60);
    chk(32'(seen_q.size() > n), 32'h1);
    generation_begin_input <= 1'b0;
    wr(WOS_DIV_OFS, 32'h4);
  endtask

  task automatic t_ext();
    go(32'h13, 3, 120);
    idle(20);
    cnt(0);
    repeat (3)
    begin
      ext_pace_input <= 1'b1;
      idle(3);
      ext_pace_input <= 1'b0;
      idle(5);
    end
    idle(10);
    cnt(3);
    foreach (seen_q[i])
      chk(seen_q[i], smp(120 + i));
  endtask

  initial
  begin
    idle(5000);
    err_total++;
    summarize();
  end

  initial
  begin
    idle(4);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_delay(2);
    t_delay(7);
    t_finite();
    t_std();
    t_local();
    t_under();
    t_trig();
    t_ext();
    summarize();
  end
endmodule
